// ===== hdl/hie_top.sv
// Interrupt status, enable and request logic of the host controller
//
// Operation
// - Second isochronous buffer last descriptor done sets status bit 2.
// - First isochronous buffer last descriptor done sets status bit 1.
// - Start-of-frame state entry sets status bit 0.
// - Enable bits 9 to 0 mask status bits of equal position.
// - Global enable, configuration bit 0, also gates the interrupt output.
// - Enables reset to 0; with all enables 0 no interrupt is raised.
// - Writing 1 to an enable bit permits its event, 0 suppresses it.
// - Bit map: 9 dual-role, 8 async, 7 periodic, 6 clock, 5 suspend, 3 end.
// - Enable bit 4 gates the operational register summary interrupt.
// - Enable bits 15 to 10 are reserved, without function.
// - Status bits stay set after read, clear by writing 1.
// - Status bit 3 sets on counter zero or end-of-transfer pin.
// - Status bit 6 sets when the clock restarts after suspend.
`timescale 1ns/10ps
`default_nettype none
`include "hie_defs.svh"
module hie_top
#(
    parameter int NUM_BITS = `HIE_NUM_FLAGS
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire hie_pkg::hie_addr_t i_addr,
    input wire hie_pkg::hie_word_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_sof_start,
    input wire logic i_iso0_done,
    input wire logic i_iso1_done,
    input wire logic i_xfer_count_zero,
    input wire logic i_transfer_end_pin,
    input wire logic i_op_regs_event,
    input wire logic i_suspended,
    input wire logic i_clock_restarted,
    input wire logic i_periodic_list,
    input wire logic i_async_list,
    input wire logic i_dual_role_event,
    output logic o_irq_out_pin
);
    import hie_pkg::*;

    // ************************************************************
    // Parameter check
    // ************************************************************
    if (NUM_BITS != `HIE_NUM_FLAGS)
    begin : g_bad_width
        $error("NUM_BITS must equal the ten implemented flags");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    hie_flags_t stat_reg;
    hie_flags_t stat_next;
    hie_flags_t stat_clr;
    hie_flags_t en_reg;
    hie_flags_t en_next;
    logic cfg_reg;
    logic cfg_next;
    logic irq_next;
    hie_flags_t raw_evt;
    hie_word_t rd_mux;
    hie_word_t rdata_next;
    logic wr_stat;
    logic wr_en;
    logic wr_cfg;
    logic rd_stat;
    logic rd_en;
    logic rd_cfg;
    logic [15:0] rdata_reg;
    logic irq_reg;

    hie_evt_if evt_if ();

    // ************************************************************
    // Event sources
    // ************************************************************
    assign raw_evt[`HIE_BIT_SOF] = i_sof_start;
    assign raw_evt[`HIE_BIT_ISO0] = i_iso0_done;
    assign raw_evt[`HIE_BIT_ISO1] = i_iso1_done;
    assign raw_evt[`HIE_BIT_EOT] = i_xfer_count_zero;
    assign raw_evt[`HIE_BIT_OPR] = i_op_regs_event;
    assign raw_evt[`HIE_BIT_SUSP] = i_suspended;
    assign raw_evt[`HIE_BIT_CLKRDY] = i_clock_restarted;
    assign raw_evt[`HIE_BIT_PERIODIC] = i_periodic_list;
    assign raw_evt[`HIE_BIT_ASYNC] = i_async_list;
    assign raw_evt[`HIE_BIT_DUALROLE] = i_dual_role_event;

    hie_evt_cond u_evt_cond
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_raw (raw_evt),
        .i_transfer_end_pin (i_transfer_end_pin),
        .evt_if (evt_if.src)
    );

    // ************************************************************
    // Address decode
    // ************************************************************
    assign wr_stat = i_wr && (i_addr == `HIE_ADDR_STAT_WR);
    assign wr_en = i_wr && (i_addr == `HIE_ADDR_EN_WR);
    assign wr_cfg = i_wr && (i_addr == `HIE_ADDR_CFG_WR);
    assign rd_stat = i_rd && (i_addr == `HIE_ADDR_STAT_RD);
    assign rd_en = i_rd && (i_addr == `HIE_ADDR_EN_RD);
    assign rd_cfg = i_rd && (i_addr == `HIE_ADDR_CFG_RD);

    // ************************************************************
    // Status flags, set wins over clear
    // ************************************************************
    assign stat_clr = wr_stat ? i_wdata[NUM_BITS-1:0] : `HIE_RST_FLAGS;

    for (genvar b = 0; b < NUM_BITS; b++)
    begin : g_stat
        assign stat_next[b] = (stat_reg[b] & ~stat_clr[b]) | evt_if.evt[b];
    end

    // ************************************************************
    // Enable and global enable
    // ************************************************************
    assign en_next = wr_en ? i_wdata[NUM_BITS-1:0] : en_reg;
    assign cfg_next = wr_cfg ? i_wdata[`HIE_BIT_CFG_GLOBAL] : cfg_reg;

    // Request follows the next register values so it never lags a write
    assign irq_next = cfg_next && (|(stat_next & en_next));

    // ************************************************************
    // Read data; reserved bits and unmapped codes read zero
    // ************************************************************
    assign rd_mux = rd_stat ? {6'h00, stat_reg} :
                    rd_en ? {6'h00, en_reg} :
                    rd_cfg ? {15'h0000, cfg_reg} :
                    `HIE_RST_WORD;
    assign rdata_next = i_rd ? rd_mux : `HIE_RST_WORD;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stat_reg <= `HIE_RST_FLAGS;
            en_reg <= `HIE_RST_FLAGS;
            cfg_reg <= `HIE_RST_CFG;
        end
        else
        begin
            stat_reg <= stat_next;
            en_reg <= en_next;
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rdata_reg <= `HIE_RST_WORD;
            irq_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq_out_pin = irq_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    chk_iso1_sets_bit: assert property (
        i_iso1_done |=> stat_reg[`HIE_BIT_ISO1])
        else $error("second buffer completion did not set its flag");

    chk_iso0_sets_bit: assert property (
        i_iso0_done |=> stat_reg[`HIE_BIT_ISO0])
        else $error("first buffer completion did not set its flag");

    chk_frame_sets_bit: assert property (
        i_sof_start |=> stat_reg[`HIE_BIT_SOF] ##1 stat_reg[`HIE_BIT_SOF] || $past(wr_stat))
        else $error("frame start did not set its flag");

    chk_event_bit_map: assert property (
        (evt_if.evt != `HIE_RST_FLAGS) |=>
        ((stat_reg & $past(evt_if.evt)) == $past(evt_if.evt)))
        else $error("event set a flag at the wrong position");

    chk_status_sticky: assert property (
        (!wr_stat && (stat_reg != `HIE_RST_FLAGS)) |=>
        ((stat_reg & $past(stat_reg)) == $past(stat_reg)))
        else $error("status flag dropped without a clearing write");

    chk_status_clear: assert property (
        (wr_stat && (i_wdata[NUM_BITS-1:0] != `HIE_RST_FLAGS) && (evt_if.evt == `HIE_RST_FLAGS))
        |=> ((stat_reg & $past(i_wdata[NUM_BITS-1:0])) == `HIE_RST_FLAGS))
        else $error("writing one did not clear the flag");

    chk_enable_write: assert property (
        wr_en |=> (en_reg == $past(i_wdata[NUM_BITS-1:0])) ##1 (en_reg == $past(en_reg) || $past(wr_en)))
        else $error("enable register did not take the written value");

    chk_enable_reserved: assert property (
        rd_en |=> (o_rdata[15:NUM_BITS] == 6'h00) && (o_rdata[NUM_BITS-1:0] == $past(en_reg)))
        else $error("enable read back wrong or reserved bits set");

    chk_no_enable_no_irq: assert property (
        (en_reg == `HIE_RST_FLAGS) |-> !o_irq_out_pin)
        else $error("interrupt raised with all enables clear");

    chk_enable_reset: assert property (
        $past(i_rst) |-> (en_reg == `HIE_RST_FLAGS) && !o_irq_out_pin)
        else $error("enables not clear after reset");

    chk_irq_gating: assert property (
        o_irq_out_pin == (cfg_reg && (|(stat_reg & en_reg))))
        else $error("interrupt output disagrees with flags and enables");

    chk_global_gate: assert property (
        (wr_cfg && !i_wdata[`HIE_BIT_CFG_GLOBAL]) |=> !o_irq_out_pin ##1
        (!o_irq_out_pin || $past(wr_cfg)))
        else $error("global enable clear did not hold interrupt low");

    chk_op_regs_gate: assert property (
        (i_op_regs_event && en_reg[`HIE_BIT_OPR] && !wr_en && cfg_reg && !wr_cfg && !wr_stat)
        |=> o_irq_out_pin)
        else $error("enabled operational summary event raised no interrupt");

    chk_clock_ready: assert property (
        i_clock_restarted |=> stat_reg[`HIE_BIT_CLKRDY])
        else $error("clock restart did not set its flag");

    chk_count_zero: assert property (
        i_xfer_count_zero |=> stat_reg[`HIE_BIT_EOT])
        else $error("counter zero did not set the end flag");

    chk_op_regs_bit: assert property (
        i_op_regs_event |=> stat_reg[`HIE_BIT_OPR])
        else $error("operational summary event did not set its flag");

    chk_suspend_bit: assert property (
        i_suspended |=> stat_reg[`HIE_BIT_SUSP])
        else $error("suspend event did not set its flag");

    chk_periodic_bit: assert property (
        i_periodic_list |=> stat_reg[`HIE_BIT_PERIODIC])
        else $error("periodic list event did not set its flag");

    chk_async_bit: assert property (
        i_async_list |=> stat_reg[`HIE_BIT_ASYNC])
        else $error("async list event did not set its flag");

    chk_dual_role_bit: assert property (
        i_dual_role_event |=> stat_reg[`HIE_BIT_DUALROLE])
        else $error("dual-role event did not set its flag");

    chk_enable_unmask: assert property (
        (wr_en && cfg_reg && ((i_wdata[NUM_BITS-1:0] & stat_reg) != `HIE_RST_FLAGS))
        |=> o_irq_out_pin)
        else $error("enabling a set flag raised no interrupt");

    chk_enable_mask: assert property (
        (wr_en && (i_wdata[NUM_BITS-1:0] == `HIE_RST_FLAGS)) |=> !o_irq_out_pin)
        else $error("clearing all enables left the interrupt high");

    chk_masked_flag_quiet: assert property (
        (!i_wr && (((stat_reg | evt_if.evt) & en_reg) == `HIE_RST_FLAGS))
        |=> !o_irq_out_pin)
        else $error("masked flag raised the interrupt");

    chk_status_readback: assert property (
        rd_stat |=> (o_rdata == {6'h00, $past(stat_reg)}))
        else $error("status read back wrong or reserved bits set");

    chk_config_readback: assert property (
        rd_cfg |=> (o_rdata == {15'h0000, $past(cfg_reg)}))
        else $error("configuration read back wrong");

    chk_global_raise: assert property (
        (wr_cfg && i_wdata[`HIE_BIT_CFG_GLOBAL] && ((stat_reg & en_reg) != `HIE_RST_FLAGS))
        |=> o_irq_out_pin)
        else $error("setting the global enable raised no interrupt");

    chk_read_timing: assert property (
        !i_rd |=> (o_rdata == `HIE_RST_WORD))
        else $error("read data present without a read");

    cov_irq_rise: cover property ($rose(o_irq_out_pin));
    cov_set_and_clear: cover property (wr_stat && ((stat_clr & evt_if.evt) != `HIE_RST_FLAGS));
    cov_read_set_flag: cover property (rd_stat && (stat_reg != `HIE_RST_FLAGS));
    cov_pin_event: cover property (stat_reg[`HIE_BIT_EOT] && !$past(i_xfer_count_zero));
    cov_global_block: cover property (!cfg_reg && ((stat_reg & en_reg) != `HIE_RST_FLAGS));
endmodule // hie_top
`default_nettype wire

// ===== common/hie_defs.svh
// Register codes, flag positions and reset values of the host interrupt block
`ifndef HIE_DEFS_SVH
`define HIE_DEFS_SVH

// Register codes: read code and write code of each register
`define HIE_ADDR_CFG_RD 8'h20
`define HIE_ADDR_CFG_WR 8'ha0
`define HIE_ADDR_STAT_RD 8'h24
`define HIE_ADDR_STAT_WR 8'ha4
`define HIE_ADDR_EN_RD 8'h25
`define HIE_ADDR_EN_WR 8'ha5

// Number of implemented flags; bits 15 to 10 are reserved
`define HIE_NUM_FLAGS 10

// Flag positions, shared by status and enable
`define HIE_BIT_SOF 0
`define HIE_BIT_ISO0 1
`define HIE_BIT_ISO1 2
`define HIE_BIT_EOT 3
`define HIE_BIT_OPR 4
`define HIE_BIT_SUSP 5
`define HIE_BIT_CLKRDY 6
`define HIE_BIT_PERIODIC 7
`define HIE_BIT_ASYNC 8
`define HIE_BIT_DUALROLE 9

// Global interrupt enable position in the hardware configuration register
`define HIE_BIT_CFG_GLOBAL 0

// Reset values
`define HIE_RST_FLAGS 10'h000
`define HIE_RST_CFG 1'h0
`define HIE_RST_WORD 16'h0000

`endif

// ===== common/hie_pkg.sv
// Types of the host interrupt status and enable block
`default_nettype none
package hie_pkg;
    typedef logic [7:0] hie_addr_t;
    typedef logic [15:0] hie_word_t;
    typedef logic [9:0] hie_flags_t;
endpackage
`default_nettype wire

// ===== common/hie_evt_if.sv
// Event vector passed from the event conditioner to the status logic
`timescale 1ns/10ps
`default_nettype none
interface hie_evt_if;
    hie_pkg::hie_flags_t evt;
    modport src (output evt);
    modport dst (input evt);
endinterface
`default_nettype wire

// ===== hdl/hie_evt_cond.sv
// Event conditioner: synchronises the end-of-transfer pin and merges event pulses
`timescale 1ns/10ps
`default_nettype none
`include "hie_defs.svh"
module hie_evt_cond
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire hie_pkg::hie_flags_t i_raw,
    input wire logic i_transfer_end_pin,
    hie_evt_if.src evt_if
);
    import hie_pkg::*;

    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic end_rise;

    // ************************************************************
    // Pin synchroniser and rising edge
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= i_transfer_end_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign end_rise = pin_sync_reg & ~pin_prev_reg;
    assign evt_if.evt = i_raw | (hie_flags_t'(end_rise) << `HIE_BIT_EOT);

    // ************************************************************
    // Checks
    // ************************************************************
    chk_pin_edge_event: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(i_transfer_end_pin) |-> ##[1:3] evt_if.evt[`HIE_BIT_EOT])
        else $error("end-of-transfer pin edge gave no event");
endmodule // hie_evt_cond
`default_nettype wire

// ===== tb/hie_host_model.sv
// Register bus master standing in for the host driver software
`timescale 1ns/10ps
`default_nettype none
module hie_host_model
(
    input wire logic i_clk,
    output hie_pkg::hie_addr_t o_addr,
    output hie_pkg::hie_word_t o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [15:0] i_rdata
);
    import hie_pkg::*;
    // Never reads buffer data or starts DMA, so no ordering hazard arises
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Idle bus shows the inverse of the last value, never a stale copy
    task automatic wr_reg(input hie_addr_t a, input hie_word_t d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd_reg(input hie_addr_t a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clk);
        d = i_rdata;
    endtask
endmodule // hie_host_model
`default_nettype wire

// ===== tb/hie_top_tb.sv
// Self-checking bench of the host interrupt status and enable block
`timescale 1ns/10ps
`default_nettype none
`include "hie_defs.svh"
module hie_top_tb;
    import hie_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    hie_addr_t addr;
    hie_word_t wdata;
    logic wr, rd, irq, pin = 1'b0;
    logic [15:0] rdata;
    hie_flags_t ev = 10'h000;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2 i_clk = ~i_clk;
    hie_host_model host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .i_rdata(rdata));
    hie_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_sof_start(ev[0]), .i_iso0_done(ev[1]),
        .i_iso1_done(ev[2]), .i_xfer_count_zero(ev[3]), .i_transfer_end_pin(pin),
        .i_op_regs_event(ev[4]), .i_suspended(ev[5]), .i_clock_restarted(ev[6]),
        .i_periodic_list(ev[7]), .i_async_list(ev[8]), .i_dual_role_event(ev[9]),
        .o_irq_out_pin(irq));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input hie_addr_t a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        host.rd_reg(a, d);
        chk(what, d, exp);
    endtask
    // One-cycle event pulse, then settle into the cycle after it
    task automatic pulse(input hie_flags_t v);
        @(posedge i_clk);
        ev <= v;
        @(posedge i_clk);
        ev <= 10'h000;
        #1;
    endtask
    task automatic t_reset_state();
        rd_chk(`HIE_ADDR_EN_RD, 16'h0000, "enable reset");
        rd_chk(`HIE_ADDR_STAT_RD, 16'h0000, "status reset");
        rd_chk(`HIE_ADDR_CFG_RD, 16'h0000, "config reset");
        host.wr_reg(`HIE_ADDR_CFG_WR, 16'h0001);
        pulse(10'h3ff);
        chk("irq all masked", {15'h0, irq}, 16'h0000);
        rd_chk(`HIE_ADDR_STAT_RD, 16'h03ff, "status all set");
        rd_chk(`HIE_ADDR_STAT_RD, 16'h03ff, "status sticky");
        host.wr_reg(`HIE_ADDR_STAT_WR, 16'hffff);
        rd_chk(`HIE_ADDR_STAT_RD, 16'h0000, "status cleared");
        $display("test reset_state done");
    endtask
    task automatic t_bit_map();
        hie_word_t en;
        for (int i = 0; i < 10; i++)
        begin
            en = 16'h0001 << i;
            host.wr_reg(`HIE_ADDR_EN_WR, en);
            pulse(~en[9:0]);
            chk("irq other bits", {15'h0, irq}, 16'h0000);
            pulse(en[9:0]);
            chk("irq own bit", {15'h0, irq}, 16'h0001);
            host.wr_reg(`HIE_ADDR_EN_WR, 16'h0000);
            #1;
            chk("irq enable off", {15'h0, irq}, 16'h0000);
            host.wr_reg(`HIE_ADDR_STAT_WR, en);
            rd_chk(`HIE_ADDR_STAT_RD, 16'h03ff & ~en, "clear one bit");
            host.wr_reg(`HIE_ADDR_STAT_WR, 16'h03ff);
        end
        $display("test bit_map done");
    endtask
    task automatic t_global();
        host.wr_reg(`HIE_ADDR_EN_WR, 16'h03ff);
        host.wr_reg(`HIE_ADDR_CFG_WR, 16'h0000);
        pulse(10'h004);
        chk("irq global off", {15'h0, irq}, 16'h0000);
        host.wr_reg(`HIE_ADDR_CFG_WR, 16'h0001);
        #1;
        chk("irq global on", {15'h0, irq}, 16'h0001);
        host.wr_reg(`HIE_ADDR_STAT_WR, 16'h0004);
        #1;
        chk("irq after clear", {15'h0, irq}, 16'h0000);
        $display("test global done");
    endtask
    task automatic t_reserved();
        host.wr_reg(`HIE_ADDR_EN_WR, 16'hffff);
        rd_chk(`HIE_ADDR_EN_RD, 16'h03ff, "enable reserved");
        rd_chk(8'h30, 16'h0000, "unmapped read");
        host.wr_reg(`HIE_ADDR_EN_WR, 16'h0000);
        $display("test reserved done");
    endtask
    task automatic t_pin();
        host.wr_reg(`HIE_ADDR_EN_WR, 16'h0008);
        @(posedge i_clk);
        pin <= 1'b1;
        repeat (2) @(posedge i_clk);
        pin <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        chk("irq end pin", {15'h0, irq}, 16'h0001);
        rd_chk(`HIE_ADDR_STAT_RD, 16'h0008, "status end pin");
        host.wr_reg(`HIE_ADDR_STAT_WR, 16'h0008);
        $display("test pin done");
    endtask
    // Event and clearing write land on the same edge; the event must win
    task automatic t_set_clear();
        host.wr_reg(`HIE_ADDR_EN_WR, 16'h0001);
        fork
            host.wr_reg(`HIE_ADDR_STAT_WR, 16'h0001);
            pulse(10'h001);
        join
        chk("irq set wins", {15'h0, irq}, 16'h0001);
        rd_chk(`HIE_ADDR_STAT_RD, 16'h0001, "set wins over clear");
        host.wr_reg(`HIE_ADDR_STAT_WR, 16'h0001);
        rd_chk(`HIE_ADDR_STAT_RD, 16'h0000, "clear after set");
        $display("test set_clear done");
    endtask
    task automatic t_mid_reset();
        host.wr_reg(`HIE_ADDR_EN_WR, 16'h03ff);
        pulse(10'h3ff);
        chk("irq before reset", {15'h0, irq}, 16'h0001);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("irq after reset", {15'h0, irq}, 16'h0000);
        rd_chk(`HIE_ADDR_EN_RD, 16'h0000, "enable after reset");
        rd_chk(`HIE_ADDR_STAT_RD, 16'h0000, "status after reset");
        rd_chk(`HIE_ADDR_CFG_RD, 16'h0000, "config after reset");
        $display("test mid_reset done");
    endtask
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset_state();
        t_bit_map();
        t_global();
        t_reserved();
        t_pin();
        t_set_clear();
        t_mid_reset();
        wrap_up();
    end
endmodule // hie_top_tb
`default_nettype wire
